// File: design/vpae_map.vh
// vpae_map.vh: offsets, fields, resets and timing of the emulated phy bank
// assumes: included by the bank module and the bench; 32-bit apb, word index = paddr[7:2]
`ifndef VPAE_MAP_VH
`define VPAE_MAP_VH
// register indices, byte address is four times the index
`define VPAE_IDX_CTL 6'h00
`define VPAE_IDX_STS 6'h01
`define VPAE_IDX_ID1 6'h02
`define VPAE_IDX_ID2 6'h03
`define VPAE_IDX_ADV 6'h04
`define VPAE_IDX_LP 6'h05
`define VPAE_IDX_EXP 6'h06
`define VPAE_IDX_ISTS 6'h08
`define VPAE_IDX_IMSK 6'h09
`define VPAE_IDX_CRC 6'h0a
// emu_basic_control fields
`define VPAE_CTL_RST 15
`define VPAE_CTL_SPEED 13
`define VPAE_CTL_AN_EN 12
`define VPAE_CTL_RESTART 9
`define VPAE_CTL_DUPLEX 8
`define VPAE_CTL_WMASK 16'h7d80
`define VPAE_CTL_DEFAULT 16'h3100
// emu_basic_status constant part and completion bit
`define VPAE_STS_BASE 16'h780d
`define VPAE_STS_AN_DONE 5
// emu_local_advertisement layout
`define VPAE_ADV_WMASK 16'h0de0
`define VPAE_ADV_FIXED 16'h0001
`define VPAE_ADV_DEFAULT 16'h0de1
`define VPAE_ADV_ABIL_LO 5
`define VPAE_ADV_PSYM 10
`define VPAE_ADV_PASYM 11
// emulated partner abilities {100fd,100hd,10fd,10hd}
`define VPAE_LP_100_FULL 4'hf
`define VPAE_LP_100_HALF 4'h5
`define VPAE_LP_10_FULL 4'h3
`define VPAE_LP_10_HALF 4'h1
`define VPAE_LP_PD_100 4'h4
// chip_reset_control bits
`define VPAE_CRC_DIG 0
`define VPAE_CRC_EMU 1
// interrupt status / mask bits
`define VPAE_INT_DONE 0
`define VPAE_INT_PAGE 1
`define VPAE_INT_PD 2
// timing
`define VPAE_CLK_NS 10
`define VPAE_EMU_RST_NS 102000
`endif

// File: design/vpae_bank.v
// vpae_bank.v: emulated single-port phy register bank with apb slave
// assumes: pclk 100 mhz, straps and duplex pin static, sampled via 2 flops
//
// What this block does
// - clause 22 register bank seen as one phy
// - control and status bits like real phy
// - negotiation runs only with enable bit set
// - resets, restart bit, reload all rerun negotiation
// - complete flag, then page received, then result
// - result is advertisement anded with partner abilities
// - priority 100 full, 100 half, 10 full, 10 half
// - empty common set falls to parallel detection
// - advertisement resets to all four abilities, writable
// - advertisement writes wait for next negotiation
// - partner abilities from duplex pin and straps
// - duplex pin or strap change starts no negotiation
// - no next page, remote fault, t4 anywhere
// - common ability sets partner-able and partner bits
// - management side local, switch fabric partner
// - fallback: not able, half, strap speed, one bit
// - enable clear forces control speed and duplex
// - chip emulated reset bit self clears 102 us
`timescale 1ns/1ps
`include "vpae_map.vh"

module vpae_bank #(
  // length of the chip-level emulated reset, shorten in simulation
  parameter EMU_RST_CYCLES = `VPAE_EMU_RST_NS / `VPAE_CLK_NS,
  // identity words, values arbitrary
  parameter [15:0] ID_WORD1 = 16'h0000,
  parameter [15:0] ID_WORD2 = 16'h0000
) (
  // apb slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // static pins and straps, other domain
  input wire port0_duplex_input,
  input wire duplex_pol_strap,
  input wire speed_strap,
  input wire hardware_reset_n,
  // same-clock one-cycle requests
  input wire digital_reset_req,
  input wire config_reload_req,
  // operating mode towards the switch fabric
  output reg op_speed_100,
  output reg op_full_duplex,
  output reg op_pause_sym,
  output reg op_pause_asym,
  // interrupt
  output reg irq
);

  // negotiation sequencer states, one-hot
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_STEP1 = 4'b0010;
  localparam [3:0] S_STEP2 = 4'b0100;
  localparam [3:0] S_STEP3 = 4'b1000;

  // pin synchronisers: {hw reset, speed, polarity, duplex}
  wire [3:0] pin_raw;
  reg [3:0] pin_meta_reg;
  reg [3:0] pin_sync_reg;
  reg hw_prev_reg;

  // register bank state
  reg [15:0] ctl_reg; // writable control bits only
  reg [15:0] adv_reg; // local advertisement
  reg [3:0] lp_reg; // partner ability bits
  reg [1:0] lp_pause_reg; // partner pause, mirrors adv
  reg lp_able_reg; // partner negotiation able
  reg page_rx_reg; // page received
  reg an_done_reg; // negotiation complete
  reg soft_rst_reg; // control reset bit, reads 1 till done
  reg res_speed_reg; // negotiated 100 mb/s
  reg res_dup_reg; // negotiated full duplex
  reg [1:0] res_pause_reg; // negotiated {asym,sym}
  reg [2:0] int_sts_reg; // sticky events
  reg [2:0] int_mask_reg; // interrupt enables
  reg emu_rst_reg; // chip-level emulated reset bit
  reg [13:0] emu_cnt_reg; // its self-clear timer
  reg [3:0] state_reg;
  reg pend_reg; // negotiation wanted

  // apb decode
  wire [5:0] idx;
  wire acc, wr, rd, busy;
  wire wr_ctl, wr_adv, wr_imsk, wr_crc, rd_ists;

  // derived partner and negotiation terms
  wire hw_ok, hw_rise, hold, do_soft_rst, trig, lp_full;
  wire [3:0] lp_ab;
  wire [3:0] common;

  // read mux result
  reg [15:0] rdata;
  reg rmiss;

  // next-state terms for the sequencer
  reg [3:0] state_next;

  assign pin_raw = {hardware_reset_n, speed_strap, duplex_pol_strap, port0_duplex_input};

  // two flops per pin, second stage is the only reader of the first
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_meta_reg[gi] <= 1'b0;
          pin_sync_reg[gi] <= 1'b0;
        end else begin
          pin_meta_reg[gi] <= pin_raw[gi];
          pin_sync_reg[gi] <= pin_meta_reg[gi];
        end
      end
    end
  endgenerate

  assign hw_ok = pin_sync_reg[3];
  assign hw_rise = hw_ok & ~hw_prev_reg;
  // pins are static, so the only pin edge that restarts is the reset pin
  assign lp_full = (pin_sync_reg[0] == pin_sync_reg[1]);
  // partner abilities from strap speed and pin duplex
  assign lp_ab = pin_sync_reg[2] ?
    (lp_full ? `VPAE_LP_100_FULL : `VPAE_LP_100_HALF) :
    (lp_full ? `VPAE_LP_10_FULL : `VPAE_LP_10_HALF);
  assign common = adv_reg[`VPAE_ADV_ABIL_LO+3:`VPAE_ADV_ABIL_LO] & lp_ab;

  // bank held at defaults while either hardware or chip reset lasts
  assign hold = ~hw_ok | emu_rst_reg;
  assign busy = pend_reg | (state_reg != S_IDLE);

  // apb access phase, write and read take effect when pready is seen
  assign idx = paddr[7:2];
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign wr_ctl = wr & (idx == `VPAE_IDX_CTL);
  assign wr_adv = wr & (idx == `VPAE_IDX_ADV);
  assign wr_imsk = wr & (idx == `VPAE_IDX_IMSK);
  assign wr_crc = wr & (idx == `VPAE_IDX_CRC);
  assign rd_ists = rd & (idx == `VPAE_IDX_ISTS);
  assign do_soft_rst = wr_ctl & pwdata[`VPAE_CTL_RST];

  // every restart source but the chip emulated reset collected into one request
  assign trig = hw_rise | do_soft_rst | config_reload_req | digital_reset_req
    | (wr_ctl & pwdata[`VPAE_CTL_RESTART])
    | (wr_crc & pwdata[`VPAE_CRC_DIG]);

  // read mux, address decode as an if chain
  always @* begin
    rdata = 16'h0000;
    rmiss = 1'b0;
    if (idx == `VPAE_IDX_CTL) begin
      rdata = ctl_reg;
      rdata[`VPAE_CTL_RST] = soft_rst_reg;
      rdata[`VPAE_CTL_RESTART] = busy;
    end else if (idx == `VPAE_IDX_STS) begin
      // no t4, no remote fault, link always up
      rdata = `VPAE_STS_BASE;
      rdata[`VPAE_STS_AN_DONE] = an_done_reg;
    end else if (idx == `VPAE_IDX_ID1) begin
      rdata = ID_WORD1;
    end else if (idx == `VPAE_IDX_ID2) begin
      rdata = ID_WORD2;
    end else if (idx == `VPAE_IDX_ADV) begin
      rdata = adv_reg;
    end else if (idx == `VPAE_IDX_LP) begin
      // next page, ack, remote fault and t4 held at zero
      rdata = {4'h0, lp_pause_reg[1], lp_pause_reg[0], 1'b0, lp_reg, 5'h01};
    end else if (idx == `VPAE_IDX_EXP) begin
      rdata = {14'h0000, page_rx_reg, lp_able_reg};
    end else if (idx == `VPAE_IDX_ISTS) begin
      rdata = {13'h0000, int_sts_reg};
    end else if (idx == `VPAE_IDX_IMSK) begin
      rdata = {13'h0000, int_mask_reg};
    end else if (idx == `VPAE_IDX_CRC) begin
      rdata = {14'h0000, emu_rst_reg, 1'b0};
    end else begin
      // unsupported phy registers read as all ones
      rdata = 16'hffff;
      rmiss = 1'b1;
    end
  end

  // apb handshake: one wait state, more while negotiation runs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (pready) begin
      // drop after the completing edge
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel & penable & ~busy) begin
      // stall reads while steps run so no half result is seen
      pready <= 1'b1;
      pslverr <= rmiss;
      prdata <= pwrite ? 32'h0000_0000 : {16'h0000, rdata};
    end
  end

  // sequencer next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        // only with enable set does a pending request run
        if (pend_reg & ~hold & ctl_reg[`VPAE_CTL_AN_EN]) begin
          state_next = S_STEP1;
        end
      end
      S_STEP1: begin
        state_next = S_STEP2;
      end
      S_STEP2: begin
        state_next = S_STEP3;
      end
      S_STEP3: begin
        state_next = S_IDLE;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // sequencer, results and register bank
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
      pend_reg <= 1'b1;
      hw_prev_reg <= 1'b0;
      ctl_reg <= `VPAE_CTL_DEFAULT;
      adv_reg <= `VPAE_ADV_DEFAULT;
      lp_reg <= 4'h0;
      lp_pause_reg <= 2'b00;
      lp_able_reg <= 1'b0;
      page_rx_reg <= 1'b0;
      an_done_reg <= 1'b0;
      soft_rst_reg <= 1'b0;
      res_speed_reg <= 1'b0;
      res_dup_reg <= 1'b0;
      res_pause_reg <= 2'b00;
      emu_rst_reg <= 1'b0;
      emu_cnt_reg <= 14'h0000;
    end else begin
      hw_prev_reg <= hw_ok;
      // chip-level reset bit and its self-clear timer
      if (wr_crc & pwdata[`VPAE_CRC_EMU]) begin
        emu_rst_reg <= 1'b1;
        emu_cnt_reg <= EMU_RST_CYCLES[13:0] - 14'h0001;
      end else if (emu_rst_reg) begin
        if (emu_cnt_reg == 14'h0000) begin
          emu_rst_reg <= 1'b0;
        end else begin
          emu_cnt_reg <= emu_cnt_reg - 14'h0001;
        end
      end
      if (hold | do_soft_rst) begin
        // reset to defaults and ask for a fresh negotiation
        state_reg <= S_IDLE;
        pend_reg <= 1'b1;
        ctl_reg <= `VPAE_CTL_DEFAULT;
        adv_reg <= `VPAE_ADV_DEFAULT;
        lp_reg <= 4'h0;
        lp_able_reg <= 1'b0;
        page_rx_reg <= 1'b0;
        an_done_reg <= 1'b0;
        soft_rst_reg <= do_soft_rst;
      end else begin
        state_reg <= state_next;
        // register writes; advertisement only feeds the next run
        if (wr_ctl) begin
          ctl_reg <= pwdata[15:0] & `VPAE_CTL_WMASK;
        end
        if (wr_adv) begin
          adv_reg <= (pwdata[15:0] & `VPAE_ADV_WMASK) | `VPAE_ADV_FIXED;
        end
        // request kept if it lands mid-run
        if (trig) begin
          pend_reg <= 1'b1;
        end else if (state_reg == S_IDLE) begin
          pend_reg <= 1'b0;
        end
        case (state_reg)
          S_IDLE: begin
            if (pend_reg) begin
              // a run starts from clear flags; disabled leaves them clear
              an_done_reg <= 1'b0;
              page_rx_reg <= 1'b0;
              lp_able_reg <= 1'b0;
              if (~ctl_reg[`VPAE_CTL_AN_EN]) begin
                soft_rst_reg <= 1'b0;
              end
            end
          end
          S_STEP1: begin
            an_done_reg <= 1'b1;
          end
          S_STEP2: begin
            page_rx_reg <= 1'b1;
          end
          S_STEP3: begin
            soft_rst_reg <= 1'b0;
            lp_pause_reg <= {adv_reg[`VPAE_ADV_PASYM], adv_reg[`VPAE_ADV_PSYM]};
            if (common != 4'h0) begin
              lp_able_reg <= 1'b1;
              lp_reg <= lp_ab;
              // fixed priority over the common set
              if (common[3]) begin
                res_speed_reg <= 1'b1;
                res_dup_reg <= 1'b1;
              end else if (common[2]) begin
                res_speed_reg <= 1'b1;
                res_dup_reg <= 1'b0;
              end else if (common[1]) begin
                res_speed_reg <= 1'b0;
                res_dup_reg <= 1'b1;
              end else begin
                res_speed_reg <= 1'b0;
                res_dup_reg <= 1'b0;
              end
              // partner mirrors pause, valid only in full duplex
              res_pause_reg <= (common[3] | (~common[2] & common[1])) ?
                {adv_reg[`VPAE_ADV_PASYM], adv_reg[`VPAE_ADV_PSYM]} : 2'b00;
            end else begin
              // parallel detection: half duplex, strap speed, one bit
              lp_able_reg <= 1'b0;
              res_dup_reg <= 1'b0;
              res_speed_reg <= pin_sync_reg[2];
              res_pause_reg <= 2'b00;
              lp_reg <= pin_sync_reg[2] ? `VPAE_LP_PD_100 : `VPAE_LP_10_HALF;
            end
          end
        endcase
      end
    end
  end

  // sticky events, a read clears, a new event in that cycle wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_sts_reg <= 3'b000;
      int_mask_reg <= 3'b000;
    end else begin
      if (wr_imsk) begin
        int_mask_reg <= pwdata[2:0];
      end
      int_sts_reg <= (rd_ists ? 3'b000 : int_sts_reg)
        | {(state_reg == S_STEP3) & (common == 4'h0) & ~hold,
           (state_reg == S_STEP2) & ~hold,
           (state_reg == S_STEP1) & ~hold};
    end
  end

  // operating mode and interrupt, all from flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_speed_100 <= 1'b0;
      op_full_duplex <= 1'b0;
      op_pause_sym <= 1'b0;
      op_pause_asym <= 1'b0;
      irq <= 1'b0;
    end else begin
      irq <= |(int_sts_reg & int_mask_reg);
      if (ctl_reg[`VPAE_CTL_AN_EN]) begin
        // stored result only changes at the end of a run
        op_speed_100 <= res_speed_reg;
        op_full_duplex <= res_dup_reg;
        op_pause_sym <= res_pause_reg[0];
        op_pause_asym <= res_pause_reg[1];
      end else begin
        // forced from control bits, no pause without negotiation
        op_speed_100 <= ctl_reg[`VPAE_CTL_SPEED];
        op_full_duplex <= ctl_reg[`VPAE_CTL_DUPLEX];
        op_pause_sym <= 1'b0;
        op_pause_asym <= 1'b0;
      end
    end
  end

endmodule

// File: verification/vpae_bank_sva.sv
// vpae_bank_sva.sv: port-level checks of the emulated phy bank
// assumes: bound to vpae_bank, one clock pclk, presetn async active low
`timescale 1ns/1ps
module vpae_bank_chk (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave side
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // negotiated result
  input wire op_full_duplex,
  input wire op_pause_sym,
  input wire op_pause_asym
);
  // longest stall: shortened emulated reset plus margin
  localparam int MAXW = 60;
  // word index with no register behind it
  wire unmapped = (paddr[7:2] == 6'h07) || (paddr[7:2] > 6'h0a);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_unmapped_err: assert property (pready && unmapped |-> pslverr)
    else $error("unmapped index answered without error");
  chk_mapped_ok: assert property (pready && !unmapped |-> !pslverr)
    else $error("mapped index answered with error");
  chk_unmapped_data: assert property (pslverr && !pwrite |-> prdata == 32'h0000_ffff)
    else $error("unmapped read data wrong");
  chk_prdata_hold: assert property (!pready |-> $stable(prdata))
    else $error("read data moved outside an answer");
  chk_answer_bound: assert property ($rose(penable) |-> ##[1:MAXW] pready)
    else $error("access never answered");
  chk_pause_half: assert property (!op_full_duplex |-> !op_pause_sym && !op_pause_asym)
    else $error("pause result while half duplex");
endmodule

// File: verification/vpae_mac_model.sv
// vpae_mac_model.sv: management station model, the apb master of the bank
// assumes: one transfer at a time, same clock as the bank
`timescale 1ns/1ps
module vpae_mac_model (
  // clock and answer
  input wire pclk,
  input wire pready,
  input wire pslverr,
  input wire [31:0] prdata,
  // request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  // bound on the wait for pready, covers reset stalls
  localparam int MAXW = 200;
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // one transfer; st[0] slave error, st[1] wait ran out
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic [1:0] st);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < MAXW);
    rd = prdata;
    st = {pready !== 1'b1, pslverr};
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines show no stale value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// File: verification/test_virtual_phy_autoneg_emulation.sv
// test_virtual_phy_autoneg_emulation.sv: self-checking bench of the emulated phy bank
// assumes: vpae_bank, vpae_mac_model and vpae_bank_chk compiled first
`timescale 1ns/1ps
`include "vpae_map.vh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, (e), (g)); end end
module test_virtual_phy_autoneg_emulation;
  // emulated reset length, shortened for run time
  localparam int EMU = 20;
  // clock, reset, pins and pulses
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic port0_duplex_input = 1'b0;
  logic duplex_pol_strap = 1'b0;
  logic speed_strap = 1'b1;
  logic hardware_reset_n = 1'b1;
  logic digital_reset_req = 1'b0;
  logic config_reload_req = 1'b0;
  // apb and results
  logic psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic op_speed_100, op_full_duplex, op_pause_sym, op_pause_asym;
  wire [3:0] ops = {op_speed_100, op_full_duplex, op_pause_sym, op_pause_asym};
  // bench state and model expectations
  int num_errors = 0;
  int checks_done = 0;
  int seed = 34;
  int cyc = 0;
  int i, t0;
  logic [31:0] v, r;
  logic [15:0] adv_w;
  logic [1:0] last_st, e_exp;
  logic [3:0] lp, com, e_lp, e_op;
  logic [2:0] e_ist, msk;
  logic e_fd;
  // 100 mhz clock and a cycle count
  always #5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  vpae_mac_model u_mac (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  vpae_bank #(.EMU_RST_CYCLES(EMU)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port0_duplex_input(port0_duplex_input),
    .duplex_pol_strap(duplex_pol_strap), .speed_strap(speed_strap),
    .hardware_reset_n(hardware_reset_n), .digital_reset_req(digital_reset_req),
    .config_reload_req(config_reload_req), .op_speed_100(op_speed_100),
    .op_full_duplex(op_full_duplex), .op_pause_sym(op_pause_sym),
    .op_pause_asym(op_pause_asym), .irq(irq));
  // verdict and end of run
  task conclude();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // a wait that ran out ends the run
  task hang();
    num_errors++;
    $display("[FAIL] apb answer expected 1 seen 0");
    conclude();
  endtask
  function automatic logic [7:0] ad(input logic [5:0] idx);
    return {idx, 2'b00};
  endfunction
  task rd(input logic [7:0] a, output logic [31:0] d);
    u_mac.xfer(1'b0, a, 32'h0000_0000, d, last_st);
    if (last_st[1]) hang();
  endtask
  // upper half random: the bank ignores it
  task wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] x;
    x = $random(seed);
    u_mac.xfer(1'b1, a, {x[31:16], d}, x, last_st);
    if (last_st[1]) hang();
  endtask
  // model of one negotiation from straps and advertisement
  task calc(input logic [15:0] adv);
    lp = (port0_duplex_input == duplex_pol_strap) ? (speed_strap ? 4'hf : 4'h3)
      : (speed_strap ? 4'h5 : 4'h1);
    com = adv[8:5] & lp;
    if (com != 4'h0) begin
      e_fd = com[3] | (!com[2] & com[1]);
      e_op[3] = com[3] | com[2];
      e_lp = lp;
      e_exp = 2'h3;
      e_ist = 3'h3;
    end else begin
      e_fd = 1'b0;
      e_op[3] = speed_strap;
      e_lp = speed_strap ? 4'h4 : 4'h1;
      e_exp = 2'h2;
      e_ist = 3'h7;
    end
    e_op[2:0] = {e_fd, e_fd & adv[10], e_fd & adv[11]};
  endtask
  // read back a finished negotiation, then the interrupt path
  task check_neg();
    wr(ad(`VPAE_IDX_IMSK), {13'h0, msk});
    rd(ad(`VPAE_IDX_STS), v);
    `CHK("status", 32'h0000_782d, v)
    rd(ad(`VPAE_IDX_EXP), v);
    `CHK("expansion", {30'h0, e_exp}, v & 32'h0000_0003)
    rd(ad(`VPAE_IDX_LP), v);
    `CHK("partner", {23'h0, e_lp, 5'h00}, v & 32'h0000_e1e0)
    `CHK("result", {28'h0, e_op}, {28'h0, ops})
    `CHK("irq level", {31'h0, |(e_ist & msk)}, {31'h0, irq})
    rd(ad(`VPAE_IDX_ISTS), v);
    `CHK("int status", {29'h0, e_ist}, v)
    repeat (2) @(posedge pclk);
    `CHK("irq cleared", 32'h0, {31'h0, irq})
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    msk = 3'h7;
    rd(ad(`VPAE_IDX_CTL), v);
    `CHK("ctl reset", 32'h0000_3100, v)
    rd(ad(`VPAE_IDX_ADV), v);
    `CHK("adv reset", 32'h0000_0de1, v)
    calc(16'h0de1);
    check_neg();
    rd(ad(6'h07), v);
    `CHK("unmapped read", 33'h1_0000_ffff, {last_st[0], v})
    wr(ad(6'h0b), 16'h1234);
    `CHK("unmapped write", 32'h1, {31'h0, last_st[0]})
    $display("test defaults done");
    for (i = 0; i < 12; i++) begin
      r = $random(seed);
      adv_w = r[15:0];
      msk = r[22:20];
      wr(ad(`VPAE_IDX_ADV), adv_w);
      port0_duplex_input <= r[16];
      duplex_pol_strap <= r[17];
      speed_strap <= r[18];
      rd(ad(`VPAE_IDX_ADV), v);
      `CHK("adv write", {16'h0, adv_w & 16'h0de0 | 16'h0001}, v)
      repeat (8) @(posedge pclk);
      `CHK("result held", {28'h0, e_op}, {28'h0, ops})
      rd(ad(`VPAE_IDX_ISTS), v);
      `CHK("no self restart", 32'h0, v)
      case (i % 4)
        0: wr(ad(`VPAE_IDX_CTL), 16'h3300);
        1: begin
          digital_reset_req <= 1'b1;
          @(posedge pclk);
          digital_reset_req <= 1'b0;
        end
        2: begin
          config_reload_req <= 1'b1;
          @(posedge pclk);
          config_reload_req <= 1'b0;
        end
        default: wr(ad(`VPAE_IDX_CRC), 16'h0001);
      endcase
      calc(adv_w | 16'h0001);
      check_neg();
    end
    $display("test negotiation table done");
    wr(ad(`VPAE_IDX_ADV), 16'h0020);
    t0 = cyc;
    wr(ad(`VPAE_IDX_CRC), 16'h0002);
    v = 32'h0000_0002;
    for (i = 0; i < 50 && v[1]; i++)
      rd(ad(`VPAE_IDX_CRC), v);
    `CHK("emu reset bit", 32'h0, v & 32'h0000_0002)
    `CHK("emu reset time", 32'h1, {31'h0, cyc - t0 >= EMU && cyc - t0 < EMU + 60})
    rd(ad(`VPAE_IDX_ADV), v);
    `CHK("adv after emu reset", 32'h0000_0de1, v)
    calc(16'h0de1);
    check_neg();
    wr(ad(`VPAE_IDX_ADV), 16'h0040);
    wr(ad(`VPAE_IDX_CTL), 16'hb100);
    rd(ad(`VPAE_IDX_CTL), v);
    `CHK("soft reset clear", 32'h0000_3100, v)
    check_neg();
    hardware_reset_n <= 1'b0;
    repeat (6) @(posedge pclk);
    hardware_reset_n <= 1'b1;
    check_neg();
    $display("test resets done");
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      adv_w = {1'b0, r[0], i[1], 4'h0, i[0], 8'h00};
      wr(ad(`VPAE_IDX_CTL), adv_w);
      repeat (3) @(posedge pclk);
      rd(ad(`VPAE_IDX_CTL), v);
      `CHK("ctl forced", {16'h0, adv_w}, v)
      `CHK("forced mode", {30'h0, i[1:0]}, {30'h0, ops[3:2]})
    end
    wr(ad(`VPAE_IDX_CTL), 16'h0200);
    rd(ad(`VPAE_IDX_STS), v);
    `CHK("no negotiation", 32'h0000_780d, v)
    $display("test forced mode done");
    conclude();
  end
endmodule
bind vpae_bank vpae_bank_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .op_full_duplex(op_full_duplex), .op_pause_sym(op_pause_sym),
  .op_pause_asym(op_pause_asym));
